// ### design/tcc_timer_core.sv
// Behaviour
// - Swap set: P is duty, A period
// - Swap clear: P is period, A duty
// - Clear-select high: clear on A match
// - Clear-select low: clear on P match/overflow
// - Overflow clear only when P is zero
// - Clear-select ignored in PWM/capture modes
// - Counter readable as two RO bytes
// - Compare A held in two RW bytes
// - P compared with counter bits 15..8
// - P zero 65536, else 256*N clocks
//
// Implementation choices: register access over APB and the placing of the registers.
module tcc_timer_core (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tcc_pkg::TCC_ADDR_W-1:0] paddr,
   input wire logic [tcc_pkg::TCC_DATA_W-1:0] pwdata,
   output logic [tcc_pkg::TCC_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // Selected timer clock, one-cycle tick from on-chip prescaler
   input wire logic timerTick,
   // Timer results
   output tcc_pkg::tcc_pwm_t pwmValues,
   output logic matchAPulse,
   output logic matchPPulse,
   output logic irq
);
   import tcc_pkg::*;

   // Register state
   tcc_ctrl_t ctrl_reg;
   logic [15:0] count_reg;
   logic [15:0] compareAValue_reg;
   logic [7:0] compareP_reg;
   logic [TCC_INT_W-1:0] intStat_reg;
   logic [TCC_INT_W-1:0] intMask_reg;
   logic runDelay_reg;
   logic [TCC_DATA_W-1:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   tcc_pwm_t pwm_reg;
   logic matchA_reg;
   logic matchP_reg;
   logic irq_reg;

   // Bus decode
   wire logic accessPhase;
   wire logic readCapture;
   wire logic writeCommit;
   wire logic selCtrl;
   wire logic selCntLo;
   wire logic selCntHi;
   wire logic selCmpaLo;
   wire logic selCmpaHi;
   wire logic selCmpp;
   wire logic selIntStat;
   wire logic selIntMask;
   wire logic addrMapped;

   // Data answers a request one cycle into the access phase
   assign accessPhase = psel & penable;
   assign readCapture = accessPhase & ~pready_reg;
   assign writeCommit = accessPhase & pready_reg & pwrite;

   assign selCtrl = (paddr == TCC_OFS_CTRL);
   assign selCntLo = (paddr == TCC_OFS_CNT_LO);
   assign selCntHi = (paddr == TCC_OFS_CNT_HI);
   assign selCmpaLo = (paddr == TCC_OFS_CMPA_LO);
   assign selCmpaHi = (paddr == TCC_OFS_CMPA_HI);
   assign selCmpp = (paddr == TCC_OFS_CMPP);
   assign selIntStat = (paddr == TCC_OFS_INT_STAT);
   assign selIntMask = (paddr == TCC_OFS_INT_MASK);
   assign addrMapped = selCtrl | selCntLo | selCntHi | selCmpaLo
      | selCmpaHi | selCmpp | selIntStat | selIntMask;

   // Per-register write strobes, all on the commit edge
   wire logic wrCtrl;
   wire logic wrCmpaLo;
   wire logic wrCmpaHi;
   wire logic wrCmpp;
   wire logic wrIntStat;
   wire logic wrIntMask;
   wire logic [7:0] wrByte;
   assign wrCtrl = writeCommit & selCtrl;
   assign wrCmpaLo = writeCommit & selCmpaLo;
   assign wrCmpaHi = writeCommit & selCmpaHi;
   assign wrCmpp = writeCommit & selCmpp;
   assign wrIntStat = writeCommit & selIntStat;
   assign wrIntMask = writeCommit & selIntMask;
   // Byte registers take the low lane only
   assign wrByte = pwdata[7:0];

   // Read words, zero-extended to the bus width
   wire logic [TCC_DATA_W-1:0] rdCtrl;
   wire logic [TCC_DATA_W-1:0] rdCntLo;
   wire logic [TCC_DATA_W-1:0] rdCntHi;
   wire logic [TCC_DATA_W-1:0] rdCmpaLo;
   wire logic [TCC_DATA_W-1:0] rdCmpaHi;
   wire logic [TCC_DATA_W-1:0] rdCmpp;
   wire logic [TCC_DATA_W-1:0] rdIntStat;
   wire logic [TCC_DATA_W-1:0] rdIntMask;
   assign rdCtrl = {27'h000_0000, ctrl_reg};
   assign rdCntLo = {24'h00_0000, count_reg[7:0]};
   assign rdCntHi = {24'h00_0000, count_reg[15:8]};
   assign rdCmpaLo = {24'h00_0000, compareAValue_reg[7:0]};
   assign rdCmpaHi = {24'h00_0000, compareAValue_reg[15:8]};
   assign rdCmpp = {24'h00_0000, compareP_reg};
   assign rdIntStat = {29'h0000_0000, intStat_reg};
   assign rdIntMask = {29'h0000_0000, intMask_reg};

   // Read mux; unmapped offsets read as zero
   wire logic [TCC_DATA_W-1:0] readData;
   assign readData =
      selCtrl ? rdCtrl :
      selCntLo ? rdCntLo :
      selCntHi ? rdCntHi :
      selCmpaLo ? rdCmpaLo :
      selCmpaHi ? rdCmpaHi :
      selCmpp ? rdCmpp :
      selIntStat ? rdIntStat :
      selIntMask ? rdIntMask :
      TCC_RDATA_RST;

   // Mode-dependent clear source
   wire logic pwmMode;
   wire logic clearByA;
   wire logic clearSelEff;
   assign pwmMode = (ctrl_reg.mode == TCC_MODE_PWM);
   // Clear-select only matters in compare and timer modes
   assign clearSelEff = ((ctrl_reg.mode == TCC_MODE_COMPARE)
      | (ctrl_reg.mode == TCC_MODE_TIMER)) & ctrl_reg.counterClearSelect;
   // In PWM the period register ends the cycle instead
   assign clearByA = pwmMode ? ctrl_reg.pwmRoleSwap : clearSelEff;

   // Comparators
   wire logic [15:0] countInc;
   wire logic countTick;
   wire logic runRise;
   wire logic compareAHit;
   wire logic comparePHit;
   wire logic overflowHit;
   wire logic pIsZero;
   assign countTick = ctrl_reg.run & timerTick;
   assign runRise = ctrl_reg.run & ~runDelay_reg;
   assign countInc = count_reg + 16'h0001;
   assign pIsZero = (compareP_reg == TCC_BYTE_ZERO);
   assign compareAHit = countTick & (count_reg == compareAValue_reg);
   wire logic nextUpperIsP;
   wire logic nextLowerIsZero;
   // Upper byte only; the next count landing on N*256 ends the period
   assign nextUpperIsP = (countInc[15:8] == compareP_reg);
   assign nextLowerIsZero = (countInc[7:0] == TCC_BYTE_ZERO);
   // P zero never matches here, so the count runs on to its wrap
   assign comparePHit = countTick & ~pIsZero & nextUpperIsP
      & nextLowerIsZero;
   assign overflowHit = countTick & (count_reg == TCC_CNT_MAX);

   // Counter next value
   wire logic clearNow;
   logic [15:0] count_next;
   assign clearNow = clearByA ? compareAHit
      : comparePHit;
   always_comb begin
      count_next = count_reg;
      if (runRise) begin
         count_next = TCC_CNT_RST;
      end else if (countTick) begin
         if (clearNow) begin
            count_next = TCC_CNT_RST;
         end else begin
            // With P zero this wrap is the overflow clear
            count_next = countInc;
         end
      end
   end

   // PWM role assignment
   wire logic [15:0] compareP16;
   tcc_pwm_t pwm_next;
   assign compareP16 = {compareP_reg, TCC_BYTE_ZERO};
   assign pwm_next.period = ctrl_reg.pwmRoleSwap ? compareAValue_reg
      : compareP16;
   assign pwm_next.duty = ctrl_reg.pwmRoleSwap ? compareP16
      : compareAValue_reg;

   // Interrupt status, set wins over write-one-to-clear
   wire logic [TCC_INT_W-1:0] intSet;
   wire logic [TCC_INT_W-1:0] intClr;
   wire logic [TCC_INT_W-1:0] intStat_next;
   wire logic irq_next;
   assign intSet[TCC_INT_MATCHA_BIT] = compareAHit;
   assign intSet[TCC_INT_MATCHP_BIT] = comparePHit;
   assign intSet[TCC_INT_OVF_BIT] = overflowHit;
   assign intClr = wrIntStat ? pwdata[TCC_INT_W-1:0] : TCC_INT_RST;
   assign intStat_next = (intStat_reg & ~intClr) | intSet;
   // Built from the next status so irq rises with its status bit
   assign irq_next = |(intStat_next & intMask_reg);

   // Register next values
   wire tcc_ctrl_t ctrl_next;
   wire logic [15:0] compareA_next;
   wire logic [7:0] compareP_next;
   wire logic [TCC_INT_W-1:0] intMask_next;
   assign ctrl_next = wrCtrl ? tcc_ctrl_t'(pwdata[4:0]) : ctrl_reg;
   // Each byte of A loads alone; no latching across the two halves
   assign compareA_next = {wrCmpaHi ? wrByte : compareAValue_reg[15:8],
      wrCmpaLo ? wrByte : compareAValue_reg[7:0]};
   assign compareP_next = wrCmpp ? wrByte : compareP_reg;
   assign intMask_next = wrIntMask ? pwdata[TCC_INT_W-1:0] : intMask_reg;

   // Bus answer next values
   wire logic pready_next;
   wire logic pslverr_next;
   wire logic [TCC_DATA_W-1:0] prdata_next;
   assign pready_next = readCapture;
   assign pslverr_next = readCapture & ~addrMapped;
   // Read data is frozen until the next read, as the bus allows
   assign prdata_next = (readCapture & ~pwrite) ? readData : prdata_reg;

   // Control and compare registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= TCC_CTRL_RST;
      end else begin
         ctrl_reg <= ctrl_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         compareAValue_reg <= TCC_CMPA_RST;
      end else begin
         compareAValue_reg <= compareA_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         compareP_reg <= TCC_CMPP_RST;
      end else begin
         compareP_reg <= compareP_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         intMask_reg <= TCC_INT_RST;
      end else begin
         intMask_reg <= intMask_next;
      end
   end

   // Counter and events
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= TCC_CNT_RST;
      end else begin
         count_reg <= count_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         runDelay_reg <= 1'b0;
      end else begin
         runDelay_reg <= ctrl_reg.run;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         intStat_reg <= TCC_INT_RST;
      end else begin
         intStat_reg <= intStat_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         matchA_reg <= 1'b0;
      end else begin
         matchA_reg <= compareAHit;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         matchP_reg <= 1'b0;
      end else begin
         matchP_reg <= comparePHit;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pwm_reg <= '0;
      end else begin
         pwm_reg <= pwm_next;
      end
   end

   // APB answer, one wait state
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= pready_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pslverr_reg <= 1'b0;
      end else begin
         pslverr_reg <= pslverr_next;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prdata_reg <= TCC_RDATA_RST;
      end else begin
         prdata_reg <= prdata_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign pwmValues = pwm_reg;
   assign matchAPulse = matchA_reg;
   assign matchPPulse = matchP_reg;
   assign irq = irq_reg;

endmodule

// ### design/tcc_pkg.sv
package tcc_pkg;

   // Bus geometry
   localparam int TCC_ADDR_W = 8;
   localparam int TCC_DATA_W = 32;

   // Register byte addresses, one aligned word each
   localparam logic [7:0] TCC_OFS_CTRL = 8'h00;
   localparam logic [7:0] TCC_OFS_CNT_LO = 8'h04;
   localparam logic [7:0] TCC_OFS_CNT_HI = 8'h08;
   localparam logic [7:0] TCC_OFS_CMPA_LO = 8'h0C;
   localparam logic [7:0] TCC_OFS_CMPA_HI = 8'h10;
   localparam logic [7:0] TCC_OFS_CMPP = 8'h14;
   localparam logic [7:0] TCC_OFS_INT_STAT = 8'h18;
   localparam logic [7:0] TCC_OFS_INT_MASK = 8'h1C;

   // Control register field positions
   localparam int TCC_CTRL_CLRSEL_BIT = 0;
   localparam int TCC_CTRL_SWAP_BIT = 1;
   localparam int TCC_CTRL_MODE_LSB = 2;
   localparam int TCC_CTRL_RUN_BIT = 4;

   // Interrupt status field positions
   localparam int TCC_INT_MATCHA_BIT = 0;
   localparam int TCC_INT_MATCHP_BIT = 1;
   localparam int TCC_INT_OVF_BIT = 2;
   localparam int TCC_INT_W = 3;

   // Reset values
   localparam logic [15:0] TCC_CNT_RST = 16'h0000;
   localparam logic [15:0] TCC_CMPA_RST = 16'h0000;
   localparam logic [7:0] TCC_CMPP_RST = 8'h00;
   localparam logic [2:0] TCC_INT_RST = 3'h0;
   localparam logic [31:0] TCC_RDATA_RST = 32'h0000_0000;

   // Counter limits
   localparam logic [15:0] TCC_CNT_MAX = 16'hFFFF;
   localparam logic [7:0] TCC_BYTE_ZERO = 8'h00;

   // Operating modes
   typedef enum logic [1:0] {
      TCC_MODE_COMPARE = 2'b00,
      TCC_MODE_CAPTURE = 2'b01,
      TCC_MODE_PWM = 2'b10,
      TCC_MODE_TIMER = 2'b11
   } tcc_mode_t;

   // Control word carried as one unit
   typedef struct packed {
      logic run;
      tcc_mode_t mode;
      logic pwmRoleSwap;
      logic counterClearSelect;
   } tcc_ctrl_t;

   localparam tcc_ctrl_t TCC_CTRL_RST = '{1'b0, TCC_MODE_COMPARE, 1'b0, 1'b0};

   // PWM values handed to the output stage
   typedef struct packed {
      logic [15:0] period;
      logic [15:0] duty;
   } tcc_pwm_t;

endpackage

// ### verif/tcc_timer_core_asserts.sv
module tcc_timer_core_asserts (
   // Clock, reset and bus
   input wire logic clk_sys, rst_n, psel, penable, pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic pready, pslverr, timerTick,
   // Timer outputs
   input wire tcc_pkg::tcc_pwm_t pwmValues,
   input wire logic matchAPulse, matchPPulse, irq
);
   import tcc_pkg::*;
   wire wr = psel && penable && pready && pwrite;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence acc_s; psel && $rose(penable); endsequence
   sequence done_s; !pready ##1 pready; endsequence
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held");
   wait_state_a: assert property (acc_s |-> done_s)
      else $error("wait state wrong");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   err_zero_a: assert property (pready && pslverr && !pwrite
      |-> prdata == TCC_RDATA_RST) else $error("error read data");
   match_a_tick_a: assert property (matchAPulse |-> $past(timerTick))
      else $error("match A without tick");
   match_p_tick_a: assert property (matchPPulse |-> $past(timerTick))
      else $error("match P without tick");
   // Roles only move after a register write lands
   pwm_on_write_a: assert property ($changed(pwmValues)
      |-> $past(wr) || $past(wr, 2)) else $error("pwm moved");
   irq_cause_a: assert property ($rose(irq) |-> $past(wr, 2)
      || $past(timerTick)) else $error("irq without cause");
   // Whichever side holds P has a zero low byte
   pwm_p_byte_a: assert property (pwmValues.period[7:0] == 8'h00
      || pwmValues.duty[7:0] == 8'h00) else $error("pwm roles wrong");
endmodule

bind tcc_timer_core tcc_timer_core_asserts u_chk (.clk_sys(clk_sys),
   .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .timerTick(timerTick), .pwmValues(pwmValues),
   .matchAPulse(matchAPulse), .matchPPulse(matchPPulse), .irq(irq));

// ### verif/tcc_timer_core_bench.sv
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin \
   failCount++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module tcc_timer_core_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import tcc_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} tcc_row_t;
   logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic timerTick = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
   logic pready, pslverr, irq, mA, mP, er;
   tcc_pwm_t pwm;
   int failCount = 0, samplesChecked = 0, nP = 0, nA = 0;
   // Count-register writes must be dropped, unmapped reads give zero
   tcc_row_t rows[6] = '{'{TCC_OFS_CMPA_LO, 8'hA5, 8'hA5},
      '{TCC_OFS_CMPA_HI, 8'h5A, 8'h5A}, '{TCC_OFS_CMPP, 8'h03, 8'h03},
      '{TCC_OFS_CNT_LO, 8'hFF, 0}, '{TCC_OFS_CNT_HI, 8'hFF, 0},
      '{8'h20, 8'hFF, 0}};
   tcc_timer_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timerTick(timerTick), .pwmValues(pwm), .matchAPulse(mA),
      .matchPPulse(mP), .irq(irq));
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) nP <= nP + mP;
   always @(posedge clk_sys) nA <= nA + mA;
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys) penable <= 1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] e);
      apb(0, a, 0);
      `CHK(rd, e)
   endtask
   // Ticks are held off during bus traffic so counts stay exact
   task tk(input int n);
      repeat (n) @(posedge clk_sys) timerTick <= 1;
      @(posedge clk_sys) timerTick <= 0;
      repeat (2) @(posedge clk_sys);
   endtask
   task run(input logic [7:0] c);
      apb(1, TCC_OFS_CTRL, 0);
      apb(1, TCC_OFS_CTRL, c);
   endtask
   task stopTest;
      $display("fails %0d checks %0d", failCount, samplesChecked);
      if (failCount == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // About 66k cycles of tests; 80k cycles is a hang
   initial begin
      #400000;
      failCount++;
      stopTest;
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1;
      for (int i = 0; i < 32; i += 4) rchk(8'(i), 0);
      foreach (rows[i]) begin
         apb(1, rows[i].a, rows[i].d);
         rchk(rows[i].a, rows[i].e);
      end
      `CHK(er, 1'b1)
      repeat (2) @(posedge clk_sys);
      `CHK(pwm, {16'h0300, 16'h5AA5})
      apb(1, TCC_OFS_CTRL, 8'h02);
      repeat (2) @(posedge clk_sys);
      `CHK(pwm, {16'h5AA5, 16'h0300})
      apb(1, TCC_OFS_CMPA_HI, 0);
      apb(1, TCC_OFS_CMPA_LO, 5);
      run(8'h11);
      tk(8);
      rchk(TCC_OFS_CNT_LO, 2);
      rchk(TCC_OFS_INT_STAT, 1);
      `CHK(er, 1'b0)
      `CHK(nA, 1)
      `CHK(irq, 1'b0)
      apb(1, TCC_OFS_INT_MASK, 1);
      tk(0);
      `CHK(irq, 1'b1)
      apb(1, TCC_OFS_INT_STAT, 1);
      tk(0);
      `CHK(irq, 1'b0)
      apb(1, TCC_OFS_CMPP, 1);
      run(8'h10);
      nP = 0;
      tk(259);
      rchk(TCC_OFS_CNT_LO, 3);
      `CHK(nP, 1)
      run(8'h19);
      tk(8);
      rchk(TCC_OFS_CNT_LO, 8);
      apb(1, TCC_OFS_CMPP, 0);
      run(8'h10);
      tk(300);
      rchk(TCC_OFS_CNT_HI, 1);
      rchk(TCC_OFS_CNT_LO, 8'h2C);
      tk(65238);
      rchk(TCC_OFS_CNT_LO, 2);
      // Mid-run reset must bring every register back to zero
      rst_n <= 0;
      repeat (2) @(posedge clk_sys);
      `CHK(irq, 1'b0)
      `CHK(pwm, 32'h0000_0000)
      rst_n <= 1;
      rchk(TCC_OFS_CMPA_LO, 0);
      rchk(TCC_OFS_CNT_HI, 0);
      stopTest;
   end
endmodule
